/* File: dmcr_bank.sv */
/*
 * display misc control bank: two indexed registers and the control
 * decodes they steer (row strobe timing, panel output enables, refresh
 * fifo request, refresh count, scan mode, cursor size, clock inversion).
 * assumes the host index/data port is synchronous to i_clock (memory
 * clock, 40 MHz) and the row strobe sequencer supplies i_ras_cycle_end.
 */
`timescale 1ns/1ps
`include "dmcr_defs.svh"
module dmcr_bank (
    input  wire logic              i_clock,
    input  wire logic              i_reset_n,
    input  wire dmcr_pkg::dmcr_req_t i_req,
    output logic [7:0]             o_rdata,
    input  wire logic              i_ext_ras_short,
    input  wire logic              i_ext_fifo_deep,
    input  wire logic [3:0]        i_fifo_thr_ext,
    input  wire logic              i_refresh_five_sel,
    input  wire logic [1:0]        i_panel_class,
    input  wire logic [1:0]        i_panel_type,
    input  wire logic              i_cursor_enable,
    input  wire logic [4:0]        i_fifo_level,
    input  wire logic              i_fb_request,
    input  wire logic              i_ras_cycle_end,
    input  wire logic              i_osc_inverted,
    output dmcr_pkg::dmcr_ras_t    o_ras_timing,
    output logic                   o_panel_ctl_oe,
    output logic                   o_panel_extra_oe,
    output logic                   o_panel_power_oe,
    output logic [4:0]             o_fifo_depth,
    output logic                   o_fifo_fill_req,
    output logic [2:0]             o_refresh_per_line,
    output logic                   o_dual_scan,
    output logic                   o_single_scan,
    output logic [6:0]             o_cursor_pixels,
    output logic                   o_fb_request,
    output logic                   o_clk_invert
);
    logic [7:0] misc_r;
    logic [7:0] dscan_r;
    logic       fb_stop_r;

    wire wr_misc  = i_req.wr && (i_req.index == `DMCR_IDX_MISC);
    wire wr_dscan = i_req.wr && (i_req.index == `DMCR_IDX_DSCAN);
    wire [7:0] rd_sel =
        (i_req.index == `DMCR_IDX_MISC)  ? misc_r  :
        (i_req.index == `DMCR_IDX_DSCAN) ? dscan_r : `DMCR_RESET_VAL;

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            misc_r  <= `DMCR_RESET_VAL; // [RULE_19]
            dscan_r <= `DMCR_RESET_VAL; // [RULE_19]
        end else begin
            // reserved bits never store, so they read back zero
            if (wr_misc)
                misc_r <= i_req.data & `DMCR_MISC_MASK; // [RULE_19]
            if (wr_dscan)
                dscan_r <= i_req.data & `DMCR_DSCAN_MASK; // [RULE_19]
        end
    end

    wire ras_ext   = misc_r[`DMCR_B_RAS_EXT];
    wire fifo_thr  = misc_r[`DMCR_B_FIFO_THR];
    wire [1:0] ras_sel = {ras_ext, i_ext_ras_short};
    // half-clock units let the 6/8 settings carry their .5 edges
    dmcr_pkg::dmcr_ras_t ras_nxt;
    always_comb begin
        unique case (ras_sel)
            2'h0: ras_nxt = '{`DMCR_LOW_7, `DMCR_HIGH_7, 4'h7}; // [RULE_02]
            2'h1: ras_nxt = '{`DMCR_LOW_6, `DMCR_HIGH_6, 4'h6}; // [RULE_03]
            2'h2: ras_nxt = '{`DMCR_LOW_9, `DMCR_HIGH_9, 4'h9}; // [RULE_02]
            2'h3: ras_nxt = '{`DMCR_LOW_8, `DMCR_HIGH_8, 4'h8}; // [RULE_03]
        endcase
    end // [RULE_01]

    wire lcd_tri   = misc_r[`DMCR_B_LCD_TRI];
    wire pwr_tri   = misc_r[`DMCR_B_PWR_TRI];
    wire is_24bit  = (i_panel_type == `DMCR_PANEL_24BIT);
    wire ctl_oe    = !lcd_tri; // [RULE_05]
    wire extra_oe  = !(lcd_tri && is_24bit); // [RULE_06]
    wire power_oe  = !pwr_tri; // [RULE_07]

    wire [1:0] fifo_sel = {fifo_thr, i_ext_fifo_deep};
    wire [4:0] depth = (fifo_sel == 2'h0) ? `DMCR_DEPTH_SHORT
                                          : `DMCR_DEPTH_LONG;
    wire [4:0] empty_cnt = depth - i_fifo_level;
    logic fill_nxt;
    always_comb begin
        unique case (fifo_sel)
            2'h0: fill_nxt = (i_fifo_level < depth); // [RULE_08]
            2'h1: fill_nxt = (i_fifo_level < depth); // [RULE_09]
            2'h2: fill_nxt = (i_fifo_level <= `DMCR_HALF_LONG); // [RULE_10]
            2'h3: fill_nxt = (empty_cnt >= {1'b0, i_fifo_thr_ext}); // [RULE_11]
        endcase
    end

    wire [2:0] refresh_nxt =
        dscan_r[`DMCR_B_REF_LINE] ? `DMCR_REF_ONE :
        (i_refresh_five_sel ? `DMCR_REF_FIVE : `DMCR_REF_THREE); // [RULE_13]
    wire colour    = (i_panel_class == `DMCR_CLASS_COLOUR);
    wire dual_nxt  = colour && dscan_r[`DMCR_B_DUAL_SCAN]; // [RULE_14]
    wire single_nxt = colour && !dscan_r[`DMCR_B_DUAL_SCAN]; // [RULE_14]
    wire [6:0] cursor_nxt = !i_cursor_enable ? 7'h00 :
        (dscan_r[`DMCR_B_CUR_SIZE] ? `DMCR_CUR_LARGE
                                   : `DMCR_CUR_SMALL); // [RULE_16]

    // stop takes hold only on a row strobe cycle boundary
    always_ff @(posedge i_clock) begin
        if (!i_reset_n)
            fb_stop_r <= 1'b0;
        else if (i_ras_cycle_end)
            fb_stop_r <= dscan_r[`DMCR_B_FB_STOP]; // [RULE_15]
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_rdata            <= `DMCR_RESET_VAL;
            o_ras_timing       <= '0;
            o_panel_ctl_oe     <= 1'b0;
            o_panel_extra_oe   <= 1'b0;
            o_panel_power_oe   <= 1'b0;
            o_fifo_depth       <= '0;
            o_fifo_fill_req    <= 1'b0;
            o_refresh_per_line <= '0;
            o_dual_scan        <= 1'b0;
            o_single_scan      <= 1'b0;
            o_cursor_pixels    <= '0;
            o_fb_request       <= 1'b0;
            o_clk_invert       <= 1'b0;
        end else begin
            o_rdata            <= i_req.rd ? rd_sel : `DMCR_RESET_VAL;
            o_ras_timing       <= ras_nxt;
            o_panel_ctl_oe     <= ctl_oe;
            o_panel_extra_oe   <= extra_oe;
            o_panel_power_oe   <= power_oe;
            o_fifo_depth       <= depth;
            o_fifo_fill_req    <= fill_nxt;
            o_refresh_per_line <= refresh_nxt;
            o_dual_scan        <= dual_nxt;
            o_single_scan      <= single_nxt;
            o_cursor_pixels    <= cursor_nxt;
            o_fb_request       <= i_fb_request && !fb_stop_r; // [RULE_15]
            // actual clock mux lives in the clock tree; this is its select
            o_clk_invert       <= dscan_r[`DMCR_B_CLK_INV]; // [RULE_18]
        end
    end
endmodule : dmcr_bank

/* File: dmcr_defs.svh */
/*
 * constants for the display misc control register bank.
 * assumes an indexed port: the host presents an index and data byte.
 */
// Operation
// RULE_01: row strobe cycle length from extended bit and extension bit
// RULE_02: 7-cycle is 4 low 3 high; 9-cycle is 5 low 4 high
// RULE_03: 6-cycle is 3.5 low 2.5 high; 8-cycle 4.5 low 3.5 high
// RULE_04: software sets extended row strobe bit only with EDO memory
// RULE_05: lcd tristate bit floats panel data and control outputs
// RULE_06: extra panel data bits float only for 24-bit active matrix
// RULE_07: power outputs ignore lcd tristate; follow power tristate bit
// RULE_08: 0/0 gives 8-entry fifo, request when no longer full
// RULE_09: 0/1 gives 20-entry fifo, request when no longer full
// RULE_10: 1/0 gives 20-entry fifo, request at or below half full
// RULE_11: 1/1 requests when empty entries reach extended threshold
// RULE_12: software picks 8-entry for text, 20-entry for graphics
// RULE_13: refresh-per-scanline bit forces one refresh, else three/five
// RULE_14: colour panel class selects dual or single scan
// RULE_15: frame-buffer stop blocks requests at end of row strobe cycle
// RULE_16: cursor size bit picks 32 or 64 pixel cursor when enabled
// RULE_17: software mirrors cursor size into cursor control register
// RULE_18: inversion bit selects inverted oscillator as pixel clock
// RULE_19: defined bits reset zero, reserved bits read zero
`ifndef DMCR_DEFS_SVH
`define DMCR_DEFS_SVH
`define DMCR_IDX_MISC        8'h20
`define DMCR_IDX_DSCAN       8'h21
`define DMCR_MISC_MASK       8'hEF
`define DMCR_DSCAN_MASK      8'hF8
`define DMCR_RESET_VAL       8'h00
`define DMCR_B_RAS_EXT       6
`define DMCR_B_LCD_TRI       5
`define DMCR_B_PWR_TRI       3
`define DMCR_B_FIFO_THR      2
`define DMCR_B_REF_LINE      7
`define DMCR_B_DUAL_SCAN     6
`define DMCR_B_FB_STOP       5
`define DMCR_B_CUR_SIZE      4
`define DMCR_B_CLK_INV       3
`define DMCR_HALF_CLK_FLAG   4'h1
`define DMCR_DEPTH_SHORT     5'h08
`define DMCR_DEPTH_LONG      5'h14
`define DMCR_HALF_LONG       5'h0A
`define DMCR_REF_ONE         3'h1
`define DMCR_REF_THREE       3'h3
`define DMCR_REF_FIVE        3'h5
`define DMCR_CLASS_COLOUR    2'h2
`define DMCR_PANEL_24BIT     2'h3
`define DMCR_CUR_SMALL       7'h20
`define DMCR_CUR_LARGE       7'h40
`define DMCR_LOW_7           4'h8
`define DMCR_HIGH_7          4'h6
`define DMCR_LOW_6           4'h7
`define DMCR_HIGH_6          4'h5
`define DMCR_LOW_9           4'hA
`define DMCR_HIGH_9          4'h8
`define DMCR_LOW_8           4'h9
`define DMCR_HIGH_8          4'h7
`endif

/* File: dmcr_pkg.sv */
/*
 * types for the display misc control register bank.
 * assumes dmcr_defs.svh is compiled alongside.
 */
package dmcr_pkg;
    // row strobe phase lengths counted in half memory clocks
    typedef struct packed {
        logic [3:0] low_half;
        logic [3:0] high_half;
        logic [3:0] total;
    } dmcr_ras_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] index;
        logic [7:0] data;
    } dmcr_req_t;
endpackage : dmcr_pkg

/* File: dmcr_bank_sva.sv */
/*
 * port assertions for dmcr_bank.
 * assumes it is bound into every dmcr_bank and that all outputs are
 * registered from the inputs of the previous edge.
 */
`timescale 1ns/1ps
module dmcr_bank_sva (
    input wire logic                i_clock,
    input wire logic                i_reset_n,
    input wire dmcr_pkg::dmcr_req_t i_req,
    input wire logic [7:0]          o_rdata,
    input wire logic [1:0]          i_panel_type,
    input wire logic                i_refresh_five_sel,
    input wire logic [1:0]          i_panel_class,
    input wire logic                i_cursor_enable,
    input wire logic [4:0]          i_fifo_level,
    input wire logic                i_fb_request,
    input wire dmcr_pkg::dmcr_ras_t o_ras_timing,
    input wire logic                o_panel_extra_oe,
    input wire logic [4:0]          o_fifo_depth,
    input wire logic                o_fifo_fill_req,
    input wire logic [2:0]          o_refresh_per_line,
    input wire logic                o_dual_scan,
    input wire logic                o_single_scan,
    input wire logic [6:0]          o_cursor_pixels,
    input wire logic                o_fb_request
);
    // outputs still show reset values on the first edge after release
    logic up_r;
    always_ff @(posedge i_clock) up_r <= i_reset_n;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    a_rdata_idle: assert property (!$past(i_req.rd) |-> o_rdata == 8'h00)
        else $error("read data outside a read");
    a_ras_sum: assert property (up_r |-> {1'b0, o_ras_timing.low_half} +
        {1'b0, o_ras_timing.high_half} == {o_ras_timing.total, 1'b0})
        else $error("row strobe phases do not add up");
    a_extra_type: assert property (up_r && $past(i_panel_type) != 2'h3
        |-> o_panel_extra_oe) else $error("extra bits floated");
    a_fill_short: assert property (up_r && o_fifo_depth == 5'h08
        |-> o_fifo_fill_req == ($past(i_fifo_level) < 5'h08))
        else $error("short fifo request wrong");
    a_refresh_sel: assert property (up_r && o_refresh_per_line != 3'h1
        |-> o_refresh_per_line == ($past(i_refresh_five_sel) ? 3'h5 : 3'h3))
        else $error("refresh count wrong");
    a_scan_class: assert property (up_r |-> !(o_dual_scan && o_single_scan)
        && ((o_dual_scan || o_single_scan) == ($past(i_panel_class) == 2'h2)))
        else $error("scan mode wrong");
    a_cursor_off: assert property (up_r && !$past(i_cursor_enable)
        |-> o_cursor_pixels == 7'h00) else $error("cursor shown");
    a_fb_gate: assert property (!$past(i_fb_request) |-> !o_fb_request)
        else $error("frame request invented");
endmodule : dmcr_bank_sva
bind dmcr_bank dmcr_bank_sva i_sva (.*);

/* File: test_dmcr_bank.sv */
/*
 * testbench for dmcr_bank: indexed reads and writes, decoded controls.
 * assumes inputs change 2 ns after the rising edge of a 40 MHz clock.
 */
`timescale 1ns/1ps
`include "dmcr_defs.svh"
module test_dmcr_bank;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    dmcr_pkg::dmcr_req_t i_req = '0;
    logic i_ext_ras_short = 1'b0, i_ext_fifo_deep = 1'b0;
    logic i_refresh_five_sel = 1'b0, i_fb_request = 1'b0;
    logic i_ras_cycle_end = 1'b0, i_osc_inverted = 1'b0;
    logic i_cursor_enable = 1'b0;
    logic [3:0] i_fifo_thr_ext = 4'h5;
    logic [1:0] i_panel_class = 2'h2, i_panel_type = 2'h2;
    logic [4:0] i_fifo_level = 5'h00;
    logic [7:0] o_rdata;
    dmcr_pkg::dmcr_ras_t o_ras_timing;
    logic o_panel_ctl_oe, o_panel_extra_oe, o_panel_power_oe;
    logic o_fifo_fill_req, o_dual_scan, o_single_scan, o_fb_request;
    logic o_clk_invert;
    logic [4:0] o_fifo_depth;
    logic [2:0] o_refresh_per_line;
    logic [6:0] o_cursor_pixels;
    int failures = 0, total_checks = 0;
    logic [3:0] tot [4] = '{4'h7, 4'h6, 4'h9, 4'h8};
    logic [4:0] lv [8] = '{5'h07, 5'h08, 5'h13, 5'h14,
                           5'h0A, 5'h0B, 5'h0F, 5'h10};
    dmcr_bank i_dut (.*);
    always #12.5 i_clock = ~i_clock;
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one access; a read compares d, a write leaves the decode settled
    task automatic acc(logic w, logic [7:0] idx, logic [7:0] d);
        i_req = '{w, !w, idx, d};
        @(posedge i_clock) #2;
        i_req = '0;
        if (!w) chk("read data", d, o_rdata);
        @(posedge i_clock) #2;
    endtask : acc
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        #200000;
        failures++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge i_clock);
        #2 i_reset_n = 1'b1;
        @(posedge i_clock) #2;
        chk("power_oe", 8'h01, o_panel_power_oe);
        acc(1'b0, `DMCR_IDX_MISC, 8'h00);
        acc(1'b0, `DMCR_IDX_DSCAN, 8'h00);
        acc(1'b1, `DMCR_IDX_MISC, 8'hFF);
        acc(1'b0, `DMCR_IDX_MISC, 8'hEF);
        acc(1'b1, `DMCR_IDX_DSCAN, 8'hFF);
        acc(1'b0, `DMCR_IDX_DSCAN, 8'hF8);
        acc(1'b1, 8'h22, 8'hFF);
        acc(1'b0, 8'h22, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            i_ext_ras_short = k[0];
            acc(1'b1, `DMCR_IDX_MISC, {1'b0, k[1], 6'h00});
            chk("ras_total", tot[k], o_ras_timing.total);
            chk("ras_low", tot[k] + 4'h1, o_ras_timing.low_half);
            chk("ras_high", tot[k] - 4'h1, o_ras_timing.high_half);
        end
        $display("test row strobe done");
        acc(1'b1, `DMCR_IDX_MISC, 8'h28);
        chk("ctl_oe", 8'h00, o_panel_ctl_oe);
        chk("extra_oe", 8'h01, o_panel_extra_oe);
        chk("power_oe", 8'h00, o_panel_power_oe);
        i_panel_type = 2'h3;
        acc(1'b1, `DMCR_IDX_MISC, 8'h20);
        chk("extra_oe", 8'h00, o_panel_extra_oe);
        chk("power_oe", 8'h01, o_panel_power_oe);
        $display("test tristate done");
        for (int i = 0; i < 8; i++) begin
            i_ext_fifo_deep = i[1];
            i_fifo_level = lv[i];
            acc(1'b1, `DMCR_IDX_MISC, {5'h00, i[2], 2'h0});
            chk("depth", i[2:1] == 2'h0 ? 8'h08 : 8'h14, o_fifo_depth);
            chk("fill_req", {7'h00, !i[0]}, o_fifo_fill_req);
        end
        $display("test fifo done");
        i_refresh_five_sel = 1'b1;
        i_cursor_enable = 1'b1;
        acc(1'b1, `DMCR_IDX_DSCAN, 8'h48);
        chk("refresh", 8'h05, o_refresh_per_line);
        chk("dual", 8'h01, o_dual_scan);
        chk("cursor", 8'h20, o_cursor_pixels);
        chk("clk_invert", 8'h01, o_clk_invert);
        acc(1'b1, `DMCR_IDX_DSCAN, 8'h90);
        chk("refresh", 8'h01, o_refresh_per_line);
        chk("single", 8'h01, o_single_scan);
        chk("cursor", 8'h40, o_cursor_pixels);
        chk("clk_invert", 8'h00, o_clk_invert);
        // a panel class other than colour passive must drop both scan modes
        i_panel_class = 2'h1;
        acc(1'b1, `DMCR_IDX_DSCAN, 8'h40);
        chk("dual", 8'h00, o_dual_scan);
        chk("single", 8'h00, o_single_scan);
        i_panel_class = 2'h2;
        $display("test display modes done");
        i_fb_request = 1'b1;
        acc(1'b1, `DMCR_IDX_DSCAN, 8'h20);
        chk("fb_request", 8'h01, o_fb_request);
        i_ras_cycle_end = 1'b1;
        @(posedge i_clock) #2 i_ras_cycle_end = 1'b0;
        repeat (2) @(posedge i_clock);
        #2 chk("fb_request", 8'h00, o_fb_request);
        $display("test frame stop done");
        // reset in mid-run must clear programmed bits and the held stop
        i_reset_n = 1'b0;
        repeat (2) @(posedge i_clock);
        #2 i_reset_n = 1'b1;
        @(posedge i_clock) #2;
        chk("ctl_oe", 8'h01, o_panel_ctl_oe);
        chk("fb_request", 8'h01, o_fb_request);
        acc(1'b0, `DMCR_IDX_MISC, 8'h00);
        acc(1'b0, `DMCR_IDX_DSCAN, 8'h00);
        $display("test second reset done");
        conclude();
    end
endmodule : test_dmcr_bank
